/* logic/oam_ea_calc.sv */
`timescale 1ns/100ps
`default_nettype none
// base plus offset; base never written back
module oam_ea_calc
  import oam_pkg::*;
(
  // operand select
  input  wire logic [3:0]  reg_num,
  input  wire logic [15:0] reg_val,
  input  wire logic [15:0] pc_val,
  input  wire logic [15:0] offset,
  // result
  output logic      [15:0] eff_addr
);
  logic [15:0] base;

  always_comb begin
    if (reg_num == OAM_PC_NUM) begin
      base = pc_val;
    end else if (reg_num == OAM_FLAG_NUM) begin
      base = OAM_ZERO;
    end else begin
      base = reg_val;
    end
    eff_addr = base + offset;
  end
endmodule : oam_ea_calc
`default_nettype wire

/* logic/oam_pkg.sv */
package oam_pkg;
  localparam int          OAM_DW        = 16;
  localparam int          OAM_RW        = 4;
  localparam logic [1:0]  OAM_SRC_REG   = 2'h0;
  localparam logic [1:0]  OAM_SRC_IDX   = 2'h1;
  localparam logic        OAM_DST_REG   = 1'b0;
  localparam logic        OAM_DST_IDX   = 1'b1;
  localparam logic [3:0]  OAM_PC_NUM    = 4'h0;
  localparam logic [3:0]  OAM_FLAG_NUM  = 4'h2;
  localparam logic [15:0] OAM_WORD_STEP = 16'h0002;
  localparam logic [15:0] OAM_ZERO      = 16'h0000;
  localparam logic [15:0] OAM_BYTE_MASK = 16'h00ff;
  localparam logic [15:0] OAM_PC_RST    = 16'h0000;
  localparam int          OAM_BIT_N_W   = 15;
  localparam int          OAM_BIT_N_B   = 7;

  typedef enum logic [2:0] {
    OAM_IDLE = 3'b000,
    OAM_SRCX = 3'b001,
    OAM_DSTX = 3'b011,
    OAM_DONE = 3'b010
  } oam_state_t;
endpackage : oam_pkg

/* logic/oam_top.sv */
// How it works
// - register mode hands the register content straight on and a copy leaves the source as is.
// - a byte-width result written to a register has its high byte cleared.
// - flags of a byte operation come from the low eight bits of the result.
// - indexed mode address is base register plus the signed extension word.
// - address calculation never writes the base registers.
// - one extended operand means two words, two extended operands mean three.
// - the program counter steps past every extension word as it is fetched.
// - symbolic mode address is program counter plus the extension word.
// - absolute mode uses the extension word itself with a zero base.
// - all four modes work for both source and destination.
// - source field 00 or destination bit 0 selects register mode.
// - source 01 or destination 1 is indexed; base pc is symbolic, base flag register absolute.
`timescale 1ns/100ps
`default_nettype none
module oam_top
  import oam_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // decoder side
  input  wire logic        dec_valid,
  input  wire logic [1:0]  source_mode_field,
  input  wire logic        dst_mode,
  input  wire logic [3:0]  src_reg,
  input  wire logic [3:0]  dst_reg,
  input  wire logic        byte_op,
  input  wire logic [15:0] pc_start,
  output logic             dec_ready,
  // register file read
  input  wire logic [15:0] src_reg_val,
  input  wire logic [15:0] dst_reg_val,
  // extension word fetch
  output logic             fetch_req,
  output logic [15:0]      fetch_addr,
  input  wire logic        fetch_ack,
  input  wire logic [15:0] fetch_data,
  // memory access side
  output logic             op_valid,
  output logic [15:0]      src_addr,
  output logic [15:0]      dst_addr,
  output logic             src_is_reg,
  output logic             dst_is_reg,
  output logic [15:0]      src_operand,
  output logic [15:0]      pc_next,
  output logic [1:0]       instr_words,
  // register write-back of results
  input  wire logic        res_valid,
  input  wire logic [15:0] res_data,
  output logic             wb_en,
  output logic [3:0]       wb_reg,
  output logic [15:0]      wb_data,
  output logic             flag_n,
  output logic             flag_z
);
  typedef struct packed {
    oam_state_t  st;
    logic [15:0] pc;
    logic        sx;
    logic        dx;
    logic [3:0]  snum;
    logic [3:0]  dr;
    logic        bop;
    logic        req;
    logic [15:0] faddr;
    logic        ov;
    logic [15:0] sa;
    logic [15:0] da;
    logic        sir;
    logic        dir;
    logic [15:0] sop;
    logic [1:0]  words;
    logic        wb;
    logic [15:0] wbd;
    logic        fn;
    logic        fz;
    logic        rdy;
  } oam_regs_t;

  oam_regs_t   q_reg;
  oam_regs_t   q_next;
  logic [15:0] ea_out;
  logic [3:0]  ea_reg;
  logic [15:0] ea_val;
  logic [15:0] res_m;

  // word and register-number widths are fixed by the port list
  if (OAM_DW != 16 || OAM_RW != 4) begin : g_width_check
    $error("oam_top needs sixteen-bit words and four-bit register numbers");
  end
  if (OAM_BIT_N_B >= OAM_BIT_N_W || OAM_BIT_N_W >= OAM_DW) begin : g_sign_check
    $error("oam_top sign bit positions out of range");
  end

  // one adder shared by both operands, source first
  always_comb begin
    if (q_reg.st == OAM_SRCX) begin
      ea_reg = q_reg.snum;
      ea_val = src_reg_val;
    end else begin
      ea_reg = q_reg.dr;
      ea_val = dst_reg_val;
    end
  end

  oam_ea_calc u_ea (
    .reg_num  (ea_reg),
    .reg_val  (ea_val),
    .pc_val   (q_reg.faddr),
    .offset   (fetch_data),
    .eff_addr (ea_out)
  );

  assign res_m = q_reg.bop ? (res_data & OAM_BYTE_MASK) : res_data;

  always_comb begin
    q_next    = q_reg;
    q_next.ov = 1'b0;
    q_next.wb = 1'b0;
    case (q_reg.st)
      OAM_IDLE: begin
        if (dec_valid) begin
          q_next.sx    = (source_mode_field == OAM_SRC_IDX);
          q_next.dx    = (dst_mode == OAM_DST_IDX);
          q_next.sir   = (source_mode_field == OAM_SRC_REG);
          q_next.dir   = (dst_mode == OAM_DST_REG);
          q_next.snum  = src_reg;
          q_next.dr    = dst_reg;
          q_next.bop   = byte_op;
          q_next.sop   = src_reg_val;
          q_next.sa    = OAM_ZERO;
          q_next.da    = OAM_ZERO;
          q_next.pc    = pc_start + OAM_WORD_STEP;
          q_next.faddr = pc_start + OAM_WORD_STEP;
          q_next.words = 2'd1 + {1'b0, q_next.sx} + {1'b0, q_next.dx};
          if (q_next.sx) begin
            q_next.st  = OAM_SRCX;
            q_next.req = 1'b1;
          end else if (q_next.dx) begin
            q_next.st  = OAM_DSTX;
            q_next.req = 1'b1;
          end else begin
            q_next.st  = OAM_DONE;
          end
        end
      end
      OAM_SRCX: begin
        // source word first, destination word follows it
        if (fetch_ack) begin
          q_next.sa    = ea_out;
          q_next.pc    = q_reg.pc + OAM_WORD_STEP;
          q_next.faddr = q_reg.faddr + OAM_WORD_STEP;
          if (q_reg.dx) begin
            q_next.st  = OAM_DSTX;
          end else begin
            q_next.st  = OAM_DONE;
            q_next.req = 1'b0;
          end
        end
      end
      OAM_DSTX: begin
        // last extension word, fetching stops here
        if (fetch_ack) begin
          q_next.da  = ea_out;
          q_next.pc  = q_reg.pc + OAM_WORD_STEP;
          q_next.st  = OAM_DONE;
          q_next.req = 1'b0;
        end
      end
      OAM_DONE: begin
        q_next.ov = 1'b1;
        q_next.st = OAM_IDLE;
      end
      default: begin
        q_next.st = OAM_IDLE;
      end
    endcase
    // ready kept in a register so dec_ready leaves a flop
    q_next.rdy = (q_next.st == OAM_IDLE);
    // result write-back into destination register
    if (res_valid) begin
      q_next.wb  = q_reg.dir;
      q_next.wbd = res_m;
      // flags follow the width of the operation
      q_next.fz  = (res_m == OAM_ZERO);
      q_next.fn  = q_reg.bop ? res_data[OAM_BIT_N_B] : res_data[OAM_BIT_N_W];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q_reg    <= '0;
      q_reg.st <= OAM_IDLE;
      q_reg.pc <= OAM_PC_RST;
      // decoder ready straight out of reset
      q_reg.rdy <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // every output is a plain register bit
  assign dec_ready   = q_reg.rdy;
  assign fetch_req   = q_reg.req;
  assign fetch_addr  = q_reg.faddr;
  assign op_valid    = q_reg.ov;
  assign src_addr    = q_reg.sa;
  assign dst_addr    = q_reg.da;
  assign src_is_reg  = q_reg.sir;
  assign dst_is_reg  = q_reg.dir;
  assign src_operand = q_reg.sop;
  assign pc_next     = q_reg.pc;
  assign instr_words = q_reg.words;
  assign wb_en       = q_reg.wb;
  assign wb_reg      = q_reg.dr;
  assign wb_data     = q_reg.wbd;
  assign flag_n      = q_reg.fn;
  assign flag_z      = q_reg.fz;
endmodule : oam_top
`default_nettype wire

/* tb/oam_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module oam_asserts
  import oam_pkg::*;
(
  // clock, reset, decoder side
  input wire logic        mclk, rstn, dec_valid, dec_ready, dst_mode, byte_op,
  input wire logic [1:0]  source_mode_field,
  input wire logic [15:0] pc_start, src_reg_val,
  // fetch, operand and write-back
  input wire logic        fetch_req, fetch_ack, op_valid, src_is_reg, dst_is_reg,
  input wire logic        res_valid, wb_en, flag_z,
  input wire logic [15:0] fetch_addr, src_operand, pc_next, res_data, wb_data,
  input wire logic [1:0]  instr_words
);
  logic [15:0] pq, sq;
  logic [1:0]  nq;
  logic        dq, bq, mq;
  // instruction context captured at take, acks counted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) {pq, sq, nq, dq, bq, mq} <= '0;
    else if (dec_valid && dec_ready)
      {pq, sq, nq, dq, bq, mq} <= {pc_start, src_reg_val, 2'h0, dst_mode, byte_op,
                                   source_mode_field == OAM_SRC_REG};
    else if (fetch_req && fetch_ack) nq <= nq + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_wd; op_valid |-> instr_words == nq + 2'h1; endproperty
  a_wd: assert property (p_wd) else $error("word count off");
  property p_pc; op_valid |-> pc_next == pq + {nq + 2'h1, 1'b0}; endproperty
  a_pc: assert property (p_pc) else $error("pc not past words");
  property p_fa; fetch_req |-> fetch_addr == pq + {nq + 2'h1, 1'b0}; endproperty
  a_fa: assert property (p_fa) else $error("fetch address order");
  property p_end; $fell(fetch_req) |-> ##1 op_valid; endproperty
  a_end: assert property (p_end) else $error("no answer after fetch");
  property p_md; op_valid |-> src_is_reg == mq && dst_is_reg == !dq; endproperty
  a_md: assert property (p_md) else $error("mode decode");
  property p_ro; op_valid && src_is_reg |-> src_operand == sq; endproperty
  a_ro: assert property (p_ro) else $error("register operand");
  property p_wb; res_valid |=> wb_en == !dq; endproperty
  a_wb: assert property (p_wb) else $error("write-back enable");
  property p_hb; wb_en && bq |-> wb_data[15:8] == 8'h00; endproperty
  a_hb: assert property (p_hb) else $error("high byte not cleared");
  property p_fz;
    res_valid |=> flag_z == (bq ? $past(res_data[7:0]) == 8'h00 : $past(res_data) == 16'h0000);
  endproperty
  a_fz: assert property (p_fz) else $error("zero flag width");
  property p_rdy; op_valid |=> dec_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("not ready after answer");
  c_three: cover property (op_valid && nq == 2'h2);
  c_byte:  cover property (wb_en && bq);
  c_regs:  cover property (op_valid && src_is_reg && dst_is_reg);
endmodule : oam_asserts
bind oam_top oam_asserts u_oam_asserts (.*);
`default_nettype wire

/* tb/oam_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module oam_top_test;
  import oam_pkg::*;
  logic mclk = 0, rstn = 0, dec_valid = 0, dst_mode = 0, byte_op = 0, fetch_ack = 0, res_valid = 0;
  logic [1:0]  source_mode_field = 0;
  logic [3:0]  src_reg = 0, dst_reg = 0;
  logic [15:0] pc_start = 0, src_reg_val = 0, dst_reg_val = 0, fetch_data = 0, res_data = 0;
  wire logic dec_ready, fetch_req, op_valid, src_is_reg, dst_is_reg, wb_en, flag_n, flag_z;
  wire logic [15:0] fetch_addr, src_addr, dst_addr, src_operand, pc_next, wb_data;
  wire logic [1:0]  instr_words;
  wire logic [3:0]  wb_reg;
  int err_total = 0, comparisons = 0, cyc = 0;
  oam_top u_oam_top (.*);
  always #2 mclk = ~mclk;
  task automatic close_out();
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin err_total++; close_out(); end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin err_total++; $display("BAD %0t got %h exp %h", $time, s, e); end
  endtask : chk
  // symbolic base is the address of the extension word itself
  function automatic logic [15:0] ea(input logic [3:0] r, input logic [15:0] v, a, x);
    return r == OAM_PC_NUM ? a + x : r == OAM_FLAG_NUM ? x : v + x;
  endfunction : ea
  function automatic logic [3:0] pick(input int k);
    return k == 0 ? OAM_PC_NUM : k == 1 ? OAM_FLAG_NUM : 4'(4 + $urandom % 12);
  endfunction : pick
  logic rdy_q, opv_q, freq_q;
  always_comb rdy_q = dec_ready;
  always_comb opv_q = op_valid;
  always_comb freq_q = fetch_req;
  task automatic wait_hi(ref logic s);
    int t = 0;
    while (s !== 1'b1 && t < 60) begin @(posedge mclk); #1; t++; end
    if (s !== 1'b1) begin err_total++; $display("BAD %0t wait ran out", $time); end
  endtask : wait_hi
  // gap keeps a second ack out of the step that lowers the first
  task automatic serve(input logic [15:0] w, a, input int g);
    wait_hi(freq_q);
    repeat (g + $urandom % 3) begin @(posedge mclk); #1; end
    chk(fetch_addr, a);
    fetch_data = w; fetch_ack = 1;
    @(posedge mclk); #1 fetch_ack = 0; fetch_data = ~w;
  endtask : serve
  initial begin
    logic [15:0] xs, xd, sa, da, d;
    int n;
    void'($urandom(83222));
    repeat (12) @(posedge mclk);
    #1 rstn = 1;
    for (int i = 0; i < 80; i++) begin
      source_mode_field = i < 4 ? {1'b0, i[0]} : {1'b0, 1'($urandom)};
      dst_mode = i < 4 ? i[1] : 1'($urandom);
      src_reg = pick(source_mode_field[0] ? $urandom % 3 : 2);
      dst_reg = pick(dst_mode ? $urandom % 3 : 2);
      byte_op = 1'($urandom);
      pc_start = 16'($urandom) & 16'hfffe;
      src_reg_val = 16'($urandom); dst_reg_val = 16'($urandom);
      xs = 16'($urandom); xd = 16'($urandom); n = 1; sa = 0; da = 0;
      wait_hi(rdy_q);
      dec_valid = 1; @(posedge mclk); #1 dec_valid = 0;
      if (source_mode_field[0]) begin
        serve(xs, pc_start + OAM_WORD_STEP, 0); n++;
        sa = ea(src_reg, src_reg_val, pc_start + OAM_WORD_STEP, xs);
      end
      if (dst_mode) begin
        serve(xd, pc_start + 16'(2 * n), n - 1);
        da = ea(dst_reg, dst_reg_val, pc_start + 16'(2 * n), xd); n++;
      end
      wait_hi(opv_q);
      chk(src_addr, sa);
      chk(dst_addr, da);
      chk(pc_next, pc_start + 16'(2 * n));
      chk(16'(instr_words), 16'(n));
      if (!source_mode_field[0]) chk(src_operand, src_reg_val);
      d = i == 5 ? 16'h0100 : 16'($urandom);
      res_data = d; res_valid = 1; @(posedge mclk); #1 res_valid = 0;
      chk(16'(wb_en), 16'(!dst_mode));
      if (!dst_mode) chk(wb_data, byte_op ? d & OAM_BYTE_MASK : d);
      if (!dst_mode) chk(16'(wb_reg), 16'(dst_reg));
      chk(16'({flag_n, flag_z}), 16'(byte_op ? {d[7], d[7:0] == 0} : {d[15], d == 0}));
    end
    close_out();
  end
endmodule : oam_top_test
`default_nettype wire
